//--- hdl/xpt_ctrl.sv
// Crosspoint switch control: parallel port, serial link, input and switch registers
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "xpt_regs.svh"
module xpt_ctrl #(
    parameter int AMPS = 4,
    parameter int WORD_BITS = `XPT_WORD_BITS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // Switch controls
    output logic [AMPS-1:0] amp_enable,
    output logic [AMPS*3-1:0] amp_input_sel,
    output logic shutdown
);
    import xpt_pkg::*;

    // Parallel port word: [3:0] code, [5:4] address, [9] ce_n, [10] wr_n, [11] apply_n
    logic [11:0] par_ff, nxt_par;
    logic ctrl_ff, nxt_ctrl;
    logic [2:0] sclk_m_ff, sclk_s_ff;
    xpt_pkg::chan_code_t in_reg_ff [AMPS], nxt_in_reg [AMPS];
    xpt_pkg::chan_code_t sw_reg_ff [AMPS], nxt_sw_reg [AMPS];
    logic [31:0] nxt_prdata;
    logic [31:0] prdata_ff;
    logic ser_dout;
    logic [WORD_BITS-1:0] ser_word;
    logic ser_strobe;
    logic ser_load_ff, nxt_ser_load;
    logic [AMPS-1:0] par_hit, ser_hit;
    logic boot_ff, nxt_boot;
    logic wr_n, ce_n, apply_n;
    amp_addr_t par_addr;
    chan_code_t par_code;
    amp_addr_t ser_addr;
    chan_code_t ser_code;
    logic bus_wr;

    function automatic logic [AMPS-1:0] addr_dec(input amp_addr_t a);
        addr_dec = '0;
        addr_dec[a] = 1'b1;
    endfunction

    // Two-stage synchronisers for link pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_m_ff <= 3'h2;
            sclk_s_ff <= 3'h2;
        end else begin
            sclk_m_ff <= {sclk, cs_n, din};
            sclk_s_ff <= sclk_m_ff;
        end
    end

    xpt_serial #(.WORD_BITS(WORD_BITS)) u_serial (
        .pclk(pclk),
        .presetn(presetn),
        .sclk_s(sclk_s_ff[2]),
        .cs_n_s(sclk_s_ff[1]),
        .din_s(sclk_s_ff[0]),
        .dout_ff(ser_dout),
        .word_ff(ser_word),
        .word_strobe(ser_strobe)
    );
    assign dout = ser_dout;

    assign par_code = par_ff[3:0];
    assign par_addr = par_ff[5:4];
    assign ce_n = par_ff[9];
    assign wr_n = par_ff[10];
    assign apply_n = par_ff[11];
    assign ser_code = ser_word[`XPT_CODE_HI:`XPT_CODE_LO];
    assign ser_addr = ser_word[`XPT_ADDR_HI:`XPT_ADDR_LO];
    assign bus_wr = psel && penable && pwrite;
    assign par_hit = addr_dec(par_addr);
    assign ser_hit = addr_dec(ser_addr);

    always_comb begin
        nxt_par = par_ff;
        nxt_ctrl = ctrl_ff;
        nxt_boot = boot_ff;
        nxt_in_reg = in_reg_ff;
        nxt_sw_reg = sw_reg_ff;
        // Captured word is valid one cycle after the strobe, so apply it then
        nxt_ser_load = ser_strobe;
        if (bus_wr && paddr == `XPT_PAR_OFFSET)
            nxt_par = pwdata[11:0];
        if (bus_wr && paddr == `XPT_CTRL_OFFSET)
            nxt_ctrl = pwdata[`XPT_CTRL_SHUTDOWN_REQUEST_BIT];
        // Addressed input register follows the port while write and enable are low
        for (int i = 0; i < AMPS; i++) begin
            if (!wr_n && !ce_n && par_hit[i])
                nxt_in_reg[i] = par_code;
            // Serial word lands in its input register and is applied at once
            if (ser_load_ff && ser_hit[i]) begin
                nxt_in_reg[i] = ser_code;
                nxt_sw_reg[i] = ser_code;
            end
        end
        if (ser_load_ff)
            nxt_boot = 1'b0;
        // Apply low makes switch registers transparent; high holds them except for a serial word load
        if (!apply_n) begin
            for (int i = 0; i < AMPS; i++)
                nxt_sw_reg[i] = nxt_in_reg[i];
            nxt_boot = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_ff <= `XPT_PAR_IDLE;
            ctrl_ff <= 1'b0;
            boot_ff <= 1'b1;
            ser_load_ff <= 1'b0;
            for (int i = 0; i < AMPS; i++) begin
                in_reg_ff[i] <= 4'h8;
                sw_reg_ff[i] <= 4'h8;
            end
        end else begin
            par_ff <= nxt_par;
            ctrl_ff <= nxt_ctrl;
            boot_ff <= nxt_boot;
            ser_load_ff <= nxt_ser_load;
            in_reg_ff <= nxt_in_reg;
            sw_reg_ff <= nxt_sw_reg;
        end
    end

    // Amplifier enables and input selects from the switch registers
    always_comb begin
        for (int i = 0; i < AMPS; i++) begin
            amp_enable[i] = !sw_reg_ff[i][3] && !ctrl_ff;
            amp_input_sel[i*3 +: 3] = sw_reg_ff[i][2:0];
        end
    end
    assign shutdown = ctrl_ff;

    // APB read data
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            `XPT_CTRL_OFFSET: nxt_prdata = {31'h0, ctrl_ff};
            `XPT_PAR_OFFSET: nxt_prdata = {20'h0, par_ff};
            `XPT_SER_OFFSET: nxt_prdata = {16'h0, ser_word};
            `XPT_STAT_OFFSET: nxt_prdata = {27'h0, boot_ff, amp_enable};
            `XPT_SEL_OFFSET: nxt_prdata = {4'h0, amp_input_sel, 12'h000, sw_reg_ff[3][3], sw_reg_ff[2][3],
                sw_reg_ff[1][3], sw_reg_ff[0][3]};
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (psel && !penable)
            prdata_ff <= nxt_prdata;
    end
    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == `XPT_CTRL_OFFSET || paddr == `XPT_PAR_OFFSET ||
        paddr == `XPT_SER_OFFSET || paddr == `XPT_STAT_OFFSET || paddr == `XPT_SEL_OFFSET);

    a_boot_all_off: assert property (@(posedge pclk) disable iff (!presetn)
        boot_ff |-> amp_enable == '0) else $error("amplifier on before programming");
    a_hold_when_high: assert property (@(posedge pclk) disable iff (!presetn)
        $past(apply_n) && !$past(ser_load_ff) |-> $stable(amp_input_sel) && $stable(amp_enable) || $changed(ctrl_ff))
        else $error("switch moved while apply high");
    a_shutdown_request_off: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff |-> amp_enable == '0 && shutdown) else $error("shutdown not honoured");
    a_code_top_off: assert property (@(posedge pclk) disable iff (!presetn)
        sw_reg_ff[0][3] |-> !amp_enable[0]) else $error("disabled amplifier driving");
    a_amp_two_off: assert property (@(posedge pclk) disable iff (!presetn)
        sw_reg_ff[2][3] |-> !amp_enable[2]) else $error("disabled amplifier two driving");
    a_in_reg_load: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_n && !ce_n && !ser_load_ff |=> in_reg_ff[$past(par_addr)] == $past(par_code))
        else $error("input register missed write");
    a_unaddressed_held: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_n && !ce_n && par_addr != 2'h2 && !ser_load_ff |=> $stable(in_reg_ff[2]))
        else $error("unaddressed input register moved");
    a_apply_copy: assert property (@(posedge pclk) disable iff (!presetn)
        !apply_n && wr_n |=> sw_reg_ff[1] == in_reg_ff[1]) else $error("switch register not transparent");
    a_sel_decode: assert property (@(posedge pclk) disable iff (!presetn)
        amp_input_sel[5:3] == sw_reg_ff[1][2:0]) else $error("input index decode wrong");
    a_others_latched: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_n || ce_n) && !ser_load_ff |=> $stable(in_reg_ff[2])) else $error("latched input register moved");
    a_ser_apply: assert property (@(posedge pclk) disable iff (!presetn)
        ser_load_ff |=> sw_reg_ff[$past(ser_addr)] == $past(ser_code)) else $error("serial word not applied");
endmodule

//--- hdl/xpt_regs.svh
// Register offsets, field positions, reset values and timing counts for the crosspoint control
`ifndef XPT_REGS_SVH
`define XPT_REGS_SVH
`define XPT_CTRL_OFFSET 12'h000
`define XPT_PAR_OFFSET 12'h004
`define XPT_SER_OFFSET 12'h008
`define XPT_STAT_OFFSET 12'h00C
`define XPT_SEL_OFFSET 12'h010
`define XPT_CTRL_SHUTDOWN_REQUEST_BIT 0
`define XPT_CTRL_RESET 32'h0000_0000
`define XPT_PAR_IDLE 12'hE00
`define XPT_SER_IDLE 2'h1
`define XPT_WORD_BITS 16
`define XPT_DOUT_DELAY 16
`define XPT_CODE_HI 15
`define XPT_CODE_LO 12
`define XPT_ADDR_HI 9
`define XPT_ADDR_LO 8
`endif

//--- hdl/xpt_pkg.sv
// Types shared by the crosspoint control files
package xpt_pkg;
    typedef logic [3:0] chan_code_t;
    typedef logic [1:0] amp_addr_t;
    typedef logic [15:0] ser_word_t;
endpackage

//--- hdl/xpt_serial.sv
// Serial shift path: 16-bit word capture and cascade output
`timescale 1ns/100ps
`include "xpt_regs.svh"
module xpt_serial #(
    parameter int WORD_BITS = `XPT_WORD_BITS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Synchronised link pins
    input wire logic sclk_s,
    input wire logic cs_n_s,
    input wire logic din_s,
    // Results
    output logic dout_ff,
    output logic [WORD_BITS-1:0] word_ff,
    output logic word_strobe
);
    import xpt_pkg::*;
    logic sclk_d_ff;
    logic cs_d_ff;
    logic [WORD_BITS-1:0] shift_ff;
    logic [WORD_BITS-1:0] nxt_shift;
    logic [WORD_BITS-1:0] nxt_word;
    logic nxt_dout;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic rise;
    logic fall;
    logic cs_rise;

    assign rise = sclk_s & ~sclk_d_ff;
    assign fall = ~sclk_s & sclk_d_ff;
    assign cs_rise = cs_n_s & ~cs_d_ff;
    assign word_strobe = cs_rise && (cnt_ff >= 5'(WORD_BITS));

    always_comb begin
        nxt_shift = shift_ff;
        nxt_dout = dout_ff;
        nxt_cnt = cnt_ff;
        nxt_word = word_ff;
        if (!cs_n_s && rise) begin
            nxt_shift = {shift_ff[WORD_BITS-2:0], din_s};
            if (cnt_ff < 5'(WORD_BITS))
                nxt_cnt = cnt_ff + 5'h1;
        end
        // Cascade bit leaves on the falling edge, fifteen rises after entry
        if (!cs_n_s && fall)
            nxt_dout = shift_ff[WORD_BITS-1];
        if (cs_n_s)
            nxt_cnt = 5'h0;
        if (word_strobe)
            nxt_word = shift_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
            shift_ff <= '0;
            dout_ff <= 1'b0;
            cnt_ff <= 5'h0;
            word_ff <= '0;
        end else begin
            sclk_d_ff <= sclk_s;
            cs_d_ff <= cs_n_s;
            shift_ff <= nxt_shift;
            dout_ff <= nxt_dout;
            cnt_ff <= nxt_cnt;
            word_ff <= nxt_word;
        end
    end

    a_dout_falls_only: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(dout_ff) |-> $past(fall) && !$past(cs_n_s)) else $error("cascade changed off falling edge");
    a_dout_hold_cs: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cs_n_s) |-> $stable(dout_ff)) else $error("cascade moved while deselected");
endmodule

//--- verif/xpt_host.sv
// Serial link master model that drives the crosspoint control's link pins
`timescale 1ns/100ps
module xpt_host (
    // Link pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    logic [31:0] echo;
    initial begin
        sclk = 1'h0;
        cs_n = 1'h1;
        din = 1'h0;
        echo = 32'h0;
    end
    // One frame, MSB first; the cascade pin is sampled after every falling edge
    task automatic send(input logic [31:0] w);
        #3;
        cs_n = 1'h0;
        for (int i = 0; i < 32; i++) begin
            din = w[31-i];
            #80;
            if (i > 0) begin
                echo = {echo[30:0], dout};
            end
            sclk = 1'h1;
            #80;
            sclk = 1'h0;
        end
        #80;
        echo = {echo[30:0], dout};
        cs_n = 1'h1;
        // Released data line shows no held value
        din = ~din;
    endtask
endmodule

//--- verif/crosspoint_switch_control_tb.sv
// Self-checking bench for the crosspoint control over APB and the serial link
`timescale 1ns/100ps
`include "xpt_regs.svh"
module crosspoint_switch_control_tb;
    import xpt_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sclk, cs_n, din, dout, shutdown, err;
    logic [3:0] amp_enable;
    logic [11:0] amp_input_sel;
    logic [11:0] esel = 12'h000;
    logic [31:0] rd;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;

    always #5 pclk = ~pclk;

    xpt_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
        .cs_n(cs_n), .din(din), .dout(dout), .amp_enable(amp_enable), .amp_input_sel(amp_input_sel),
        .shutdown(shutdown));
    xpt_host i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    task automatic finish_test;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Parallel port levels: code, amp address, chip enable, write and apply strobes
    task automatic par(input logic [3:0] code, input logic [1:0] a, input logic ce_n, wr_n, apply_n);
        apb(1'h1, `XPT_PAR_OFFSET, {20'h0, apply_n, wr_n, ce_n, 3'h0, a, code});
    endtask

    // Compare enables, and the selects of enabled amplifiers only
    task automatic sw(input logic [3:0] e);
        logic [11:0] m;
        m = 12'h000;
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            if (e[i]) begin
                m[3*i+:3] = 3'h7;
            end
        end
        check("amp_enable", 32'(amp_enable), 32'(e));
        check("amp_input_sel", 32'(amp_input_sel & m), 32'(esel & m));
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        sw(4'h0);
        apb(1'h0, `XPT_STAT_OFFSET, 32'h0);
        check("status", rd, 32'h10);
        for (int r = 0; r < 2; r++) begin
            for (int a = 0; a < 4; a++) begin
                par(4'(a + 4 * r), 2'(a), 1'h0, 1'h0, 1'h1);
                par(4'(a + 4 * r), 2'(a), 1'h0, 1'h1, 1'h1);
            end
            sw(r == 1 ? 4'hF : 4'h0);
            par(4'h0, 2'h0, 1'h1, 1'h1, 1'h0);
            for (int a = 0; a < 4; a++) begin
                esel[3*a+:3] = 3'(a + 4 * r);
            end
            sw(4'hF);
            par(4'h0, 2'h0, 1'h1, 1'h1, 1'h1);
        end
        par(4'h1, 2'h1, 1'h1, 1'h0, 1'h0);
        par(4'h1, 2'h1, 1'h1, 1'h1, 1'h1);
        sw(4'hF);
        par(4'hA, 2'h2, 1'h0, 1'h0, 1'h0);
        par(4'hA, 2'h2, 1'h1, 1'h1, 1'h1);
        sw(4'hB);
        apb(1'h1, `XPT_CTRL_OFFSET, 32'h1);
        repeat (2) @(posedge pclk);
        check("shutdown", 32'(shutdown), 32'h1);
        check("amp_enable", 32'(amp_enable), 32'h0);
        apb(1'h1, `XPT_CTRL_OFFSET, 32'h0);
        sw(4'hB);
        apb(1'h0, 12'h020, 32'h0);
        check("pslverr", 32'(err), 32'h1);
        check("unmapped read", rd, 32'h0);
        i_host.send({16'hA5C3, 16'h6300});
        repeat (6) @(posedge pclk);
        esel[11:9] = 3'h6;
        sw(4'hB);
        check("cascade", 32'(i_host.echo[16:1]), 32'hA5C3);
        finish_test;
    end
endmodule
